/* common/bfw_pkg.sv */
package bfw_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL     = 6'h02;
    localparam logic [5:0] IDX_THR      = 6'h03;
    localparam logic [5:0] IDX_CNT      = 6'h04;
    localparam logic [5:0] IDX_PORT     = 6'h05;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h08;
    localparam logic [5:0] IDX_IRQ_EN   = 6'h09;
    localparam logic [5:0] IDX_IRQ_CLR  = 6'h0a;

    // Buffer depths selected by depth_select
    localparam logic [9:0] DEPTH_SMALL = 10'h0ff;
    localparam logic [9:0] DEPTH_LARGE = 10'h200;

    // Control field positions used on write
    localparam int CTRL_DEPTH_BIT = 7;
    localparam int CTRL_PURGE_BIT = 4;
    localparam int CTRL_TMSB_BIT  = 2;

    // Values after reset
    localparam logic       RST_DEPTH_SEL = 1'h0;
    localparam logic       RST_TMSB      = 1'h0;
    localparam logic [7:0] RST_THR       = 8'h00;
    localparam logic [3:0] RST_IRQ       = 4'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Read image of buffer_control
    typedef struct packed {
        logic       depth_select;
        logic       high_warning;
        logic       low_warning;
        logic       purge_strobe;
        logic       reserved;
        logic       threshold_msb;
        logic [1:0] fill_count_upper;
    } bfw_ctrl_t;

    // Interrupt events, one bit each
    typedef struct packed {
        logic underflow;
        logic overflow;
        logic low_rise;
        logic high_rise;
    } bfw_evt_t;

endpackage : bfw_pkg

/* verilog/bfw_top.sv */
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps

// Behaviour
// - depth_select one gives 255, zero 512
// - high_warning when depth minus fill within threshold
// - low_warning when fill within threshold
// - purge_strobe empties buffer, reads back zero
// - threshold_msb counts only in 512 mode
// - control bits 1:0 show fill bits 9:8
// - threshold_level holds threshold bits 7:0
// - fill_count shows low fill bits, resets zero
// - port write appends, port read removes oldest
// - port access never advances the address
module bfw_top #(
    parameter int AW        = 8,
    parameter int MAX_DEPTH = 512
) (
    // Clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // Write address channel
    input  wire logic [AW-1:0] awaddr,
    input  wire logic [2:0]    awprot,
    input  wire logic          awvalid,
    output logic               awready,
    // Write data channel
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready,
    // Write response channel
    output logic [1:0]         bresp,
    output logic               bvalid,
    input  wire logic          bready,
    // Read address channel
    input  wire logic [AW-1:0] araddr,
    input  wire logic [2:0]    arprot,
    input  wire logic          arvalid,
    output logic               arready,
    // Read data channel
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    output logic               rvalid,
    input  wire logic          rready,
    // Interrupt
    output logic               irq
);

    // Word index of a byte address
    function automatic logic [5:0] idx_of(input logic [AW-1:0] a);
        idx_of = a[7:2];
    endfunction : idx_of

    // Whether an index names a register
    function automatic logic mapped(input logic [5:0] i);
        mapped = (i == bfw_pkg::IDX_CTRL) || (i == bfw_pkg::IDX_THR) ||
                 (i == bfw_pkg::IDX_CNT) || (i == bfw_pkg::IDX_PORT) ||
                 (i == bfw_pkg::IDX_IRQ_STAT) ||
                 (i == bfw_pkg::IDX_IRQ_EN) || (i == bfw_pkg::IDX_IRQ_CLR);
    endfunction : mapped

    // Pointer step that wraps at the active depth
    function automatic logic [8:0] ptr_inc(input logic [8:0] p,
                                           input logic [9:0] d);
        logic [9:0] n;
        n = {1'b0, p} + 10'h001;
        ptr_inc = (n == d) ? 9'h000 : n[8:0];
    endfunction : ptr_inc

    // Storage and fill state
    logic [7:0]     mem [MAX_DEPTH];   // Byte store
    logic [9:0]     count;             // Bytes held
    logic [8:0]     wr_ptr;            // Next slot to fill
    logic [8:0]     rd_ptr;            // Oldest byte
    // Software settings
    logic           depth_sel;         // One selects small depth
    logic           thr_msb;           // Threshold bit 8
    logic [7:0]     thr;               // Threshold bits 7:0
    logic [3:0]     irq_stat;          // Sticky events
    logic [3:0]     irq_en;            // Event enables
    // Held write request
    logic [AW-1:0]  aw_addr;           // Captured write address
    logic [7:0]     w_byte;            // Captured low lane
    logic           w_lane0;           // Low lane strobe
    // Derived state
    logic [9:0]     depth;             // Active depth
    logic [9:0]     thr_eff;           // Effective threshold
    logic           high_w;            // High warning level
    logic           low_w;             // Low warning level
    logic           high_q;            // High warning last cycle
    logic           low_q;             // Low warning last cycle
    logic           wr_fire;           // Both halves held, execute
    logic [5:0]     wr_idx;            // Index of held write
    logic           rd_fire;           // Read address taken
    logic [5:0]     rd_idx;            // Index of read
    logic           push;              // Port write
    logic           push_ok;           // Port write with room
    logic           pop;               // Port read
    logic           pop_ok;            // Port read with data
    logic           purge;             // Purge request
    bfw_pkg::bfw_ctrl_t ctrl_img;      // Control read image
    bfw_pkg::bfw_evt_t  evt;           // Events this cycle
    logic [31:0]    next_rdata;        // Read mux output
    logic [1:0]     next_rresp;        // Read response
    logic [3:0]     next_irq_stat;     // Status after set and clear

    // Depth and warning levels
    assign depth   = depth_sel ? bfw_pkg::DEPTH_SMALL
                               : bfw_pkg::DEPTH_LARGE;
    // Bit 8 only counts in the large mode
    assign thr_eff = {1'b0, (~depth_sel) & thr_msb, thr};
    assign high_w  = (depth - count) <= thr_eff;
    assign low_w   = count <= thr_eff;

    // Request decode; a fixed address keeps hitting the port
    assign wr_fire = ~awready & ~wready & ~bvalid;
    assign wr_idx  = idx_of(aw_addr);
    assign rd_fire = arvalid & arready;
    assign rd_idx  = idx_of(araddr);
    assign push    = wr_fire && w_lane0 &&
                     (wr_idx == bfw_pkg::IDX_PORT);
    assign pop     = rd_fire && (rd_idx == bfw_pkg::IDX_PORT);
    assign push_ok = push && (count < depth);
    assign pop_ok  = pop && (count != 10'h000);
    assign purge   = wr_fire && w_lane0 &&
                     (wr_idx == bfw_pkg::IDX_CTRL) &&
                     w_byte[bfw_pkg::CTRL_PURGE_BIT];

    // Control read image; purge reads zero
    always_comb begin
        ctrl_img                  = '0;
        ctrl_img.depth_select     = depth_sel;
        ctrl_img.high_warning     = high_w;
        ctrl_img.low_warning      = low_w;
        ctrl_img.purge_strobe     = 1'b0;
        ctrl_img.threshold_msb    = thr_msb;
        ctrl_img.fill_count_upper = count[9:8];
    end

    // Write channels: each half taken alone, released after response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= bfw_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
            end
            if (wr_fire) begin
                // Unknown address answers with an error
                bvalid <= 1'b1;
                bresp  <= mapped(wr_idx) ? bfw_pkg::RESP_OKAY
                                         : bfw_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Held write payload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr <= '0;
            w_byte  <= 8'h00;
            w_lane0 <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_byte  <= wdata[7:0];
                w_lane0 <= wstrb[0];
            end
        end
    end

    // Software settings
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            depth_sel <= bfw_pkg::RST_DEPTH_SEL;
            thr_msb   <= bfw_pkg::RST_TMSB;
            thr       <= bfw_pkg::RST_THR;
            irq_en    <= bfw_pkg::RST_IRQ;
        end else if (wr_fire && w_lane0) begin
            if (wr_idx == bfw_pkg::IDX_CTRL) begin
                // Depth change is safe only on an empty buffer
                depth_sel <= w_byte[bfw_pkg::CTRL_DEPTH_BIT];
                thr_msb   <= w_byte[bfw_pkg::CTRL_TMSB_BIT];
            end
            if (wr_idx == bfw_pkg::IDX_THR) begin
                thr <= w_byte;
            end
            if (wr_idx == bfw_pkg::IDX_IRQ_EN) begin
                irq_en <= w_byte[3:0];
            end
        end
    end

    // Byte store; no reset needed on data
    always_ff @(posedge aclk) begin
        if (push_ok) begin
            mem[wr_ptr] <= w_byte;
        end
    end

    // Pointers and fill count; purge wins over any access
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count  <= 10'h000;
            wr_ptr <= 9'h000;
            rd_ptr <= 9'h000;
        end else if (purge) begin
            count  <= 10'h000;
            wr_ptr <= 9'h000;
            rd_ptr <= 9'h000;
        end else begin
            if (push_ok) begin
                wr_ptr <= ptr_inc(wr_ptr, depth);
            end
            if (pop_ok) begin
                rd_ptr <= ptr_inc(rd_ptr, depth);
            end
            // Same-cycle push and pop leave the count alone
            if (push_ok && !pop_ok) begin
                count <= count + 10'h001;
            end else if (pop_ok && !push_ok) begin
                count <= count - 10'h001;
            end
        end
    end

    // Read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = bfw_pkg::RESP_OKAY;
        unique case (rd_idx)
            bfw_pkg::IDX_CTRL: next_rdata[7:0] = ctrl_img;
            bfw_pkg::IDX_THR:  next_rdata[7:0] = thr;
            bfw_pkg::IDX_CNT:  next_rdata[7:0] = count[7:0];
            // Empty buffer reads zero
            bfw_pkg::IDX_PORT: begin
                next_rdata[7:0] = pop_ok ? mem[rd_ptr] : 8'h00;
            end
            bfw_pkg::IDX_IRQ_STAT: next_rdata[3:0] = irq_stat;
            bfw_pkg::IDX_IRQ_EN:   next_rdata[3:0] = irq_en;
            // Clear register is write only
            bfw_pkg::IDX_IRQ_CLR:  next_rdata = 32'h0000_0000;
            default: next_rresp = bfw_pkg::RESP_SLVERR;
        endcase
    end

    // Read channels: one read outstanding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= bfw_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Warning edges become events
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            high_q <= 1'b0;
            low_q  <= 1'b0;
        end else begin
            high_q <= high_w;
            low_q  <= low_w;
        end
    end

    assign evt.high_rise = high_w & ~high_q;
    assign evt.low_rise  = low_w & ~low_q;
    assign evt.overflow  = push & ~push_ok;
    assign evt.underflow = pop & ~pop_ok;

    // Sticky status; a new event beats a clear in the same cycle
    always_comb begin
        next_irq_stat = irq_stat;
        if (wr_fire && w_lane0 && (wr_idx == bfw_pkg::IDX_IRQ_CLR)) begin
            next_irq_stat = irq_stat & ~w_byte[3:0];
        end
        next_irq_stat = next_irq_stat | evt;
    end

    // Status and interrupt line; line lags status by one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= bfw_pkg::RST_IRQ;
            irq      <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq      <= |(irq_stat & irq_en);
        end
    end

    // Checks
    chk_depth_bound: assert property (
        @(posedge aclk) disable iff (!aresetn) count <= depth)
        else $error("fill count above active depth");

    chk_high_read: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_idx == bfw_pkg::IDX_CTRL
        |=> rdata[6] == $past(high_w))
        else $error("high warning read wrong");

    chk_low_read: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_idx == bfw_pkg::IDX_CTRL
        |=> rdata[5] == $past(low_w) && rdata[4] == 1'b0)
        else $error("low warning or purge read wrong");

    chk_purge_empty: assert property (
        @(posedge aclk) disable iff (!aresetn)
        purge |=> count == 10'h000 && wr_ptr == rd_ptr)
        else $error("purge did not empty buffer");

    chk_msb_masked: assert property (
        @(posedge aclk) disable iff (!aresetn)
        depth_sel |-> thr_eff[8] == 1'b0)
        else $error("threshold bit 8 used in small mode");

    chk_upper_read: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_idx == bfw_pkg::IDX_CTRL
        |=> rdata[1:0] == $past(count[9:8]))
        else $error("upper fill bits read wrong");

    chk_thr_store: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && w_lane0 && wr_idx == bfw_pkg::IDX_THR
        |=> thr == $past(w_byte))
        else $error("threshold not stored");

    chk_count_read: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_idx == bfw_pkg::IDX_CNT
        |=> rdata == {24'h000000, $past(count[7:0])})
        else $error("fill count read wrong");

    chk_push_count: assert property (
        @(posedge aclk) disable iff (!aresetn)
        push_ok && !pop && !purge |=> count == $past(count) + 10'h001)
        else $error("push did not raise count");

    chk_full_drop: assert property (
        @(posedge aclk) disable iff (!aresetn)
        push && count == depth && !pop && !purge |=> $stable(count))
        else $error("write into full buffer changed count");

endmodule : bfw_top

/* dv/bfw_host.sv */
`timescale 1ns/1ps

// Host side: AXI4-Lite master, one write and one read at a time
module bfw_host (
    // Clock
    input  wire logic        aclk,
    // Write channels
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    // Read channels
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    // Answers always welcome, so the ready lines never toggle
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid} = '0;
        {araddr, arvalid} = '0;
        bready = 1'b1;
        rready = 1'b1;
    end

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'h1;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr  <= ~a; // Released lines stop showing the old value
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata  <= ~d;
            end
            if (bvalid) begin
                r = bresp;
                break;
            end
        end
    endtask : wr

    // Read: address held until taken, data taken with rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr  <= ~a;
            end
            if (rvalid) begin
                d = rdata;
                r = rresp;
                break;
            end
        end
    endtask : rd
endmodule : bfw_host

/* dv/test_byte_fifo_watermark_control.sv */
`timescale 1ns/1ps

module test_byte_fifo_watermark_control;
    // Bus and pins
    logic        aclk, aresetn, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    // Bookkeeping
    int          err_count = 0;
    int          n_tests   = 0;
    int          cyc       = 0;

    bfw_top #(.AW(8), .MAX_DEPTH(512)) DUT (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .irq(irq));

    bfw_host host (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // 200 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Hang guard: some 560 accesses need far fewer cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    // Compare helpers, one per kind of result
    task automatic chk_data(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk_data

    task automatic chk_resp(input string nm, input logic [1:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk_resp

    task automatic chk_pin(input logic e);
        n_tests++;
        if (irq !== e) begin
            err_count++;
            $display("[ERR] irq exp %b got %b", e, irq);
        end
    endtask : chk_pin

    // Register access by index, byte address is four times it
    task automatic wreg(input logic [5:0] i, input logic [7:0] d);
        logic [1:0] r;
        host.wr({i, 2'h0}, {24'h0, d}, r);
        chk_resp("bresp", bfw_pkg::RESP_OKAY, r);
    endtask : wreg

    task automatic rreg(input logic [5:0] i, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        host.rd({i, 2'h0}, d, r);
        chk_resp("rresp", bfw_pkg::RESP_OKAY, r);
        chk_data($sformatf("reg %h", i), {24'h0, e}, d);
    endtask : rreg

    // Reset image; low warning holds since 0 <= 0
    task automatic t_reset();
        rreg(bfw_pkg::IDX_CTRL, 8'h20);
        rreg(bfw_pkg::IDX_THR, 8'h00);
        rreg(bfw_pkg::IDX_CNT, 8'h00);
        rreg(bfw_pkg::IDX_IRQ_STAT, 8'h02);
        chk_pin(1'b0);
        $display("test reset done");
    endtask : t_reset

    // Bytes leave oldest first, same address every time
    task automatic t_order();
        wreg(bfw_pkg::IDX_THR, 8'h03);
        rreg(bfw_pkg::IDX_THR, 8'h03);
        for (int i = 0; i < 5; i++) wreg(bfw_pkg::IDX_PORT, 8'ha0 + i[7:0]);
        rreg(bfw_pkg::IDX_CNT, 8'h05);
        rreg(bfw_pkg::IDX_CTRL, 8'h00);
        for (int i = 0; i < 5; i++) rreg(bfw_pkg::IDX_PORT, 8'ha0 + i[7:0]);
        rreg(bfw_pkg::IDX_CNT, 8'h00);
        rreg(bfw_pkg::IDX_PORT, 8'h00);
        rreg(bfw_pkg::IDX_CNT, 8'h00);
        $display("test order done");
    endtask : t_order

    // Small depth filled to the brim, overflow dropped, then purge
    task automatic t_full();
        wreg(bfw_pkg::IDX_CTRL, 8'h90);
        for (int i = 0; i < 255; i++) wreg(bfw_pkg::IDX_PORT, i[7:0]);
        rreg(bfw_pkg::IDX_CNT, 8'hff);
        rreg(bfw_pkg::IDX_CTRL, 8'hc0);
        wreg(bfw_pkg::IDX_PORT, 8'h77);
        rreg(bfw_pkg::IDX_CNT, 8'hff);
        rreg(bfw_pkg::IDX_IRQ_STAT, 8'h0f);
        rreg(bfw_pkg::IDX_PORT, 8'h00);
        wreg(bfw_pkg::IDX_CTRL, 8'h90);
        rreg(bfw_pkg::IDX_CNT, 8'h00);
        rreg(bfw_pkg::IDX_CTRL, 8'ha0);
        $display("test full done");
    endtask : t_full

    // Threshold bit 8 and count bits 9:8, ignored at small depth
    task automatic t_ext();
        wreg(bfw_pkg::IDX_CTRL, 8'h10);
        wreg(bfw_pkg::IDX_CTRL, 8'h04);
        wreg(bfw_pkg::IDX_THR, 8'h00);
        for (int i = 0; i < 257; i++) wreg(bfw_pkg::IDX_PORT, i[7:0]);
        rreg(bfw_pkg::IDX_CTRL, 8'h45);
        rreg(bfw_pkg::IDX_CNT, 8'h01);
        wreg(bfw_pkg::IDX_CTRL, 8'h94);
        wreg(bfw_pkg::IDX_PORT, 8'h3c);
        rreg(bfw_pkg::IDX_CTRL, 8'h84);
        $display("test ext done");
    endtask : t_ext

    // Interrupt raised, masked and cleared
    task automatic t_irq();
        wreg(bfw_pkg::IDX_IRQ_CLR, 8'h0f);
        rreg(bfw_pkg::IDX_IRQ_STAT, 8'h00);
        wreg(bfw_pkg::IDX_IRQ_EN, 8'h08);
        rreg(bfw_pkg::IDX_IRQ_EN, 8'h08);
        rreg(bfw_pkg::IDX_PORT, 8'h3c);
        rreg(bfw_pkg::IDX_PORT, 8'h00);
        repeat (3) @(posedge aclk);
        chk_pin(1'b1);
        rreg(bfw_pkg::IDX_IRQ_STAT, 8'h0a);
        wreg(bfw_pkg::IDX_IRQ_EN, 8'h00);
        repeat (3) @(posedge aclk);
        chk_pin(1'b0);
        wreg(bfw_pkg::IDX_IRQ_CLR, 8'h0f);
        rreg(bfw_pkg::IDX_IRQ_STAT, 8'h00);
        $display("test irq done");
    endtask : t_irq

    // Unmapped word answers with an error and no data
    task automatic t_unmap();
        logic [31:0] d;
        logic [1:0]  r;
        host.wr(8'h40, 32'h5a, r);
        chk_resp("bresp", bfw_pkg::RESP_SLVERR, r);
        host.rd(8'h40, d, r);
        chk_resp("rresp", bfw_pkg::RESP_SLVERR, r);
        chk_data("rdata", 32'h0, d);
        $display("test unmap done");
    endtask : t_unmap

    // Main sequence
    initial begin
        aresetn = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_order();
        t_full();
        t_ext();
        t_irq();
        t_unmap();
        tally_and_finish();
    end
endmodule : test_byte_fifo_watermark_control
